// >>> logic/jtag_debug_tap_port.sv
`timescale 1ns/1ps

// Behaviour
// R01 - tdi in, tdo out, stepped by tck
// R02 - tap state follows tms per 1149.1
// R03 - trst low holds whole port reset; status, mask, irq, debug mode and bus take rst only
// R04 - mode pin sampled during reset, low selects debug
// R05 - host holds mode pin after reset release
// R06 - scan and commands only in debug mode
// R07 - one-bit bypass stage in bypass mode
// R08 - 16-bit read-only instruction, resets to bypass
// R09 - instruction reset by trst or test-logic-reset
// R10 - instruction loadable in any cpu mode
// R11 - host never loads reserved codes
// R12 - 0000 external test, 0100 sample/preload
// R13 - 0110 releases, 0111 asserts chip reset
// R14 - 101x raises debug interrupt to cpu
// R15 - 1111 is bypass and reset value
// R16 - 0001 wakes cpu from sleep
// R17 - bits 11 to 0 read as ones
// R18 - boundary chain drives and observes pins
// R19 - new instruction acts only at update-ir
module jtag_debug_tap_port #(
    parameter int BSR_W = jtag_debug_pkg::BSR_LEN
) (
    input wire logic clk,
    input wire logic rst,
    // link pins, asynchronous to clk
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    // strap pins, asynchronous to clk
    input wire logic system_reset_pin_n,
    input wire logic debug_mode_select_pin,
    // toward the cpu
    output logic chip_reset_req,
    output logic cpu_debug_irq,
    output logic cpu_wake,
    output logic irq,
    // boundary scan cells on the device pins
    input wire logic [BSR_W-1:0] pin_in,
    output logic [BSR_W-1:0] pin_out,
    output logic pin_drive,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // which data path an instruction selects, gated by debug mode
    function automatic jtag_debug_pkg::path_t path_of(input logic [3:0] op, input logic dbg);
        jtag_debug_pkg::path_t p;
        p.drive = dbg && (op == jtag_debug_pkg::OP_EXTEST); // R12 R06
        p.scan = dbg && (op == jtag_debug_pkg::OP_EXTEST || op == jtag_debug_pkg::OP_SAMPLE); // R12 R06
        return p;
    endfunction

    jtag_debug_pkg::tap_pins_t pins_raw; // pins grouped as they arrive
    jtag_debug_pkg::tap_pins_t pins_s1_r; // first synchroniser stage
    jtag_debug_pkg::tap_pins_t pins_s2_r; // second stage, safe to use
    logic tck_prev_r; // last tck level for edge finding
    logic tck_rise; // tck rising edge seen on clk
    logic tck_fall; // tck falling edge seen on clk
    logic port_rst; // reset of tap, chains, pins and cpu outputs; not status, mask, irq or mode
    logic sysrst_s1_r; // strap synchronisers
    logic sysrst_s2_r;
    logic mode_s1_r;
    logic mode_s2_r;
    logic debug_mode_r; // latched debug mode
    jtag_debug_pkg::tap_state_t state_r; // tap controller
    jtag_debug_pkg::tap_state_t state_nxt;
    logic [jtag_debug_pkg::IR_W-1:0] ir_r; // active instruction
    logic [jtag_debug_pkg::IR_W-1:0] ir_sh_r; // instruction shift stage
    logic bypass_r; // single bypass stage
    logic [BSR_W-1:0] bsr_sh_r; // boundary shift chain
    logic [BSR_W-1:0] bsr_upd_r; // boundary update latches
    jtag_debug_pkg::path_t path; // current data path
    logic [3:0] new_op; // instruction arriving at update-ir
    logic upd_ir_now; // update-ir taken this cycle
    logic [jtag_debug_pkg::EV_W-1:0] ev; // event pulses this cycle
    logic [jtag_debug_pkg::EV_W-1:0] status_r; // sticky events
    logic [jtag_debug_pkg::EV_W-1:0] mask_r; // interrupt enables
    logic [jtag_debug_pkg::EV_W-1:0] w1c; // bits cleared by software now
    logic aw_have_r; // write address held
    logic w_have_r; // write data held
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go; // both halves of a write present
    logic [31:0] rd_word; // read mux

    assign pins_raw = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};

    // two flops per pin; first feeds only second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pins_s1_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
            pins_s2_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
            tck_prev_r <= 1'b0;
        end
        else
        begin
            pins_s1_r <= pins_raw;
            pins_s2_r <= pins_s1_r;
            tck_prev_r <= pins_s2_r.tck;
        end
    end

    // tck must be well below clk/4 so no edge is missed
    assign tck_rise = pins_s2_r.tck && !tck_prev_r; // R01
    assign tck_fall = !pins_s2_r.tck && tck_prev_r; // R01
    // trst is taken without tck, so the port resets even with tck stopped
    assign port_rst = rst || !pins_s2_r.trst_n; // R03

    // strap synchronisers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sysrst_s1_r <= 1'b0;
            sysrst_s2_r <= 1'b0;
            mode_s1_r <= 1'b1;
            mode_s2_r <= 1'b1;
        end
        else
        begin
            sysrst_s1_r <= system_reset_pin_n;
            sysrst_s2_r <= sysrst_s1_r;
            mode_s1_r <= debug_mode_select_pin;
            mode_s2_r <= mode_s1_r;
        end
    end

    // follow the strap in system reset, then hold
    // both pins share the same delay, so the host hold time covers the sample
    always_ff @(posedge clk)
    begin
        if (rst)
            debug_mode_r <= 1'b0;
        else if (!sysrst_s2_r)
            debug_mode_r <= !mode_s2_r; // R04 R05
    end

    // next tap state from tms
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            jtag_debug_pkg::ST_RESET:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_RESET : jtag_debug_pkg::ST_IDLE;
            jtag_debug_pkg::ST_IDLE:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_SEL_DR : jtag_debug_pkg::ST_IDLE;
            jtag_debug_pkg::ST_SEL_DR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_SEL_IR : jtag_debug_pkg::ST_CAP_DR;
            jtag_debug_pkg::ST_CAP_DR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_EX1_DR : jtag_debug_pkg::ST_SH_DR;
            jtag_debug_pkg::ST_SH_DR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_EX1_DR : jtag_debug_pkg::ST_SH_DR;
            jtag_debug_pkg::ST_EX1_DR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_UPD_DR : jtag_debug_pkg::ST_PAU_DR;
            jtag_debug_pkg::ST_PAU_DR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_EX2_DR : jtag_debug_pkg::ST_PAU_DR;
            jtag_debug_pkg::ST_EX2_DR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_UPD_DR : jtag_debug_pkg::ST_SH_DR;
            jtag_debug_pkg::ST_UPD_DR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_SEL_DR : jtag_debug_pkg::ST_IDLE;
            jtag_debug_pkg::ST_SEL_IR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_RESET : jtag_debug_pkg::ST_CAP_IR;
            jtag_debug_pkg::ST_CAP_IR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_EX1_IR : jtag_debug_pkg::ST_SH_IR;
            jtag_debug_pkg::ST_SH_IR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_EX1_IR : jtag_debug_pkg::ST_SH_IR;
            jtag_debug_pkg::ST_EX1_IR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_UPD_IR : jtag_debug_pkg::ST_PAU_IR;
            jtag_debug_pkg::ST_PAU_IR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_EX2_IR : jtag_debug_pkg::ST_PAU_IR;
            jtag_debug_pkg::ST_EX2_IR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_UPD_IR : jtag_debug_pkg::ST_SH_IR;
            jtag_debug_pkg::ST_UPD_IR:
                state_nxt = pins_s2_r.tms ? jtag_debug_pkg::ST_SEL_DR : jtag_debug_pkg::ST_IDLE;
            default:
                state_nxt = jtag_debug_pkg::ST_RESET;
        endcase
    end

    // tap state moves only on a tck rising edge or on port reset
    always_ff @(posedge clk)
    begin
        if (port_rst)
            state_r <= jtag_debug_pkg::ST_RESET; // R03
        else if (tck_rise)
            state_r <= state_nxt; // R02
    end

    assign path = path_of(ir_r[jtag_debug_pkg::IR_W-1 -: jtag_debug_pkg::OP_W], debug_mode_r);
    assign new_op = ir_sh_r[jtag_debug_pkg::IR_W-1 -: jtag_debug_pkg::OP_W];
    assign upd_ir_now = tck_rise && state_r == jtag_debug_pkg::ST_UPD_IR;

    // instruction shift stage, blind to cpu sleep
    always_ff @(posedge clk)
    begin
        if (port_rst)
            ir_sh_r <= jtag_debug_pkg::IR_RESET;
        else if (tck_rise && state_r == jtag_debug_pkg::ST_CAP_IR)
            ir_sh_r <= ir_r;
        else if (tck_rise && state_r == jtag_debug_pkg::ST_SH_IR)
            ir_sh_r <= {pins_s2_r.tdi, ir_sh_r[jtag_debug_pkg::IR_W-1:1]}; // R01 R10
    end

    // active instruction changes only at update-ir, in test-logic-reset or on port reset
    always_ff @(posedge clk)
    begin
        if (port_rst)
            ir_r <= jtag_debug_pkg::IR_RESET; // R03 R08 R15
        else if (state_r == jtag_debug_pkg::ST_RESET)
            ir_r <= jtag_debug_pkg::IR_RESET; // R09
        else if (upd_ir_now)
            ir_r <= {new_op, jtag_debug_pkg::IR_RSVD}; // R19 R17 R10
    end

    // bypass stage: zero at capture, then one cell of delay
    always_ff @(posedge clk)
    begin
        if (port_rst)
            bypass_r <= 1'b0;
        else if (tck_rise && state_r == jtag_debug_pkg::ST_CAP_DR)
            bypass_r <= 1'b0;
        else if (tck_rise && state_r == jtag_debug_pkg::ST_SH_DR)
            bypass_r <= pins_s2_r.tdi; // R07
    end

    // boundary chain capture and shift
    always_ff @(posedge clk)
    begin
        if (port_rst)
            bsr_sh_r <= '0;
        else if (tck_rise && path.scan && state_r == jtag_debug_pkg::ST_CAP_DR)
            bsr_sh_r <= pin_in; // R18
        else if (tck_rise && path.scan && state_r == jtag_debug_pkg::ST_SH_DR)
            bsr_sh_r <= {pins_s2_r.tdi, bsr_sh_r[BSR_W-1:1]}; // R18 R01
    end

    // update latches, preloaded or driven onto pins
    always_ff @(posedge clk)
    begin
        if (port_rst)
            bsr_upd_r <= '0;
        else if (tck_rise && path.scan && state_r == jtag_debug_pkg::ST_UPD_DR)
            bsr_upd_r <= bsr_sh_r; // R18
    end

    // pin takeover registered so the outputs stay glitch free
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            pin_out <= '0;
            pin_drive <= 1'b0;
        end
        else
        begin
            pin_out <= bsr_upd_r; // R18
            pin_drive <= path.drive; // R18 R06
        end
    end

    // tdo moves on tck fall, half a period before the host samples
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe <= state_r == jtag_debug_pkg::ST_SH_IR || state_r == jtag_debug_pkg::ST_SH_DR;
            if (state_r == jtag_debug_pkg::ST_SH_IR)
                tdo <= ir_sh_r[0]; // R01
            else if (path.scan)
                tdo <= bsr_sh_r[0]; // R18 R01
            else
                tdo <= bypass_r; // R07 R01
        end
    end

    // command events in debug mode only; update event in any mode
    always_comb
    begin
        ev = '0;
        if (upd_ir_now && debug_mode_r) // R06
        begin
            ev[jtag_debug_pkg::EV_IRQ] = new_op[3:1] == jtag_debug_pkg::OP_IRQ_HI; // R14
            ev[jtag_debug_pkg::EV_WAKE] = new_op == jtag_debug_pkg::OP_WAKE; // R16
            ev[jtag_debug_pkg::EV_RST] = new_op == jtag_debug_pkg::OP_RST_ASSERT ||
                new_op == jtag_debug_pkg::OP_RST_NEGATE; // R13
        end
        ev[jtag_debug_pkg::EV_UPD] = upd_ir_now;
    end

    // chip reset level and one-cycle cpu pulses
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            chip_reset_req <= 1'b0;
            cpu_debug_irq <= 1'b0;
            cpu_wake <= 1'b0;
        end
        else
        begin
            cpu_debug_irq <= ev[jtag_debug_pkg::EV_IRQ]; // R14
            cpu_wake <= ev[jtag_debug_pkg::EV_WAKE]; // R16
            if (ev[jtag_debug_pkg::EV_RST])
                chip_reset_req <= new_op == jtag_debug_pkg::OP_RST_ASSERT; // R13
        end
    end

    // software clear requests from a status write
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    assign w1c = (wr_go && aw_addr_r == jtag_debug_pkg::OFS_STATUS && w_strb_r[0]) ?
        w_data_r[jtag_debug_pkg::EV_W-1:0] : '0;

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            status_r <= '0;
        else
            status_r <= (status_r & ~w1c) | ev;
    end

    // mask register
    always_ff @(posedge clk)
    begin
        if (rst)
            mask_r <= '0;
        else if (wr_go && aw_addr_r == jtag_debug_pkg::OFS_MASK && w_strb_r[0])
            mask_r <= w_data_r[jtag_debug_pkg::EV_W-1:0];
    end

    // level interrupt, one cycle behind status
    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(status_r & mask_r);
    end

    // write address, held until the response
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            aw_have_r <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel, independent of the address
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            w_have_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            w_have_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // write response; read-only and unmapped words answer slverr
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= jtag_debug_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r == jtag_debug_pkg::OFS_STATUS || aw_addr_r == jtag_debug_pkg::OFS_MASK) ?
                jtag_debug_pkg::RESP_OKAY : jtag_debug_pkg::RESP_SLVERR; // R08
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read mux
    always_comb
    begin
        rd_word = '0;
        case (s_axi_araddr)
            jtag_debug_pkg::OFS_INSTR: rd_word[jtag_debug_pkg::IR_W-1:0] = ir_r; // R08 R17
            jtag_debug_pkg::OFS_STATUS: rd_word[jtag_debug_pkg::EV_W-1:0] = status_r;
            jtag_debug_pkg::OFS_MASK: rd_word[jtag_debug_pkg::EV_W-1:0] = mask_r;
            jtag_debug_pkg::OFS_MODE:
            begin
                rd_word[jtag_debug_pkg::MODE_DBG] = debug_mode_r;
                rd_word[jtag_debug_pkg::MODE_CHIPRST] = chip_reset_req;
            end
            default: rd_word = '0;
        endcase
    end

    // read channel, one read in flight
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= jtag_debug_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= jtag_debug_pkg::OFS_MODE) ?
                jtag_debug_pkg::RESP_OKAY : jtag_debug_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// >>> pkg/jtag_debug_pkg.sv
package jtag_debug_pkg;

    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] OFS_INSTR = 8'h00; // instruction register image, read only
    localparam logic [7:0] OFS_STATUS = 8'h04; // sticky events, write one to clear
    localparam logic [7:0] OFS_MASK = 8'h08; // interrupt enables, same layout as status
    localparam logic [7:0] OFS_MODE = 8'h0C; // debug mode and chip reset state, read only

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // instruction register layout
    localparam int IR_W = 16; // full register width
    localparam int OP_W = 4; // live instruction bits at the top
    localparam int OP_LSB = 12; // position of the lowest instruction bit
    localparam logic [11:0] IR_RSVD = 12'hFFF; // low bits always read as ones
    localparam logic [15:0] IR_RESET = 16'hFFFF; // bypass with reserved ones

    // instruction codes in the top four bits
    localparam logic [3:0] OP_EXTEST = 4'h0;
    localparam logic [3:0] OP_WAKE = 4'h1;
    localparam logic [3:0] OP_SAMPLE = 4'h4;
    localparam logic [3:0] OP_RST_NEGATE = 4'h6;
    localparam logic [3:0] OP_RST_ASSERT = 4'h7;
    localparam logic [2:0] OP_IRQ_HI = 3'h5; // 101x, lowest bit ignored
    localparam logic [3:0] OP_BYPASS = 4'hF;

    // status and mask bit positions
    localparam int EV_IRQ = 0; // debug interrupt command seen
    localparam int EV_WAKE = 1; // wake command seen
    localparam int EV_RST = 2; // chip reset assert or negate command seen
    localparam int EV_UPD = 3; // instruction update
    localparam int EV_W = 4;

    // mode register bit positions
    localparam int MODE_DBG = 0;
    localparam int MODE_CHIPRST = 1;

    // boundary chain length, bits 0 to 297
    localparam int BSR_LEN = 298;

    // tap controller states
    typedef enum logic [3:0] {
        ST_RESET = 4'b1111,
        ST_IDLE = 4'b1100,
        ST_SEL_DR = 4'b0111,
        ST_CAP_DR = 4'b0110,
        ST_SH_DR = 4'b0010,
        ST_EX1_DR = 4'b0001,
        ST_PAU_DR = 4'b0011,
        ST_EX2_DR = 4'b0000,
        ST_UPD_DR = 4'b0101,
        ST_SEL_IR = 4'b0100,
        ST_CAP_IR = 4'b1110,
        ST_SH_IR = 4'b1010,
        ST_EX1_IR = 4'b1001,
        ST_PAU_IR = 4'b1011,
        ST_EX2_IR = 4'b1000,
        ST_UPD_IR = 4'b1101
    } tap_state_t;

    // the four link pins after synchronising
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } tap_pins_t;

    // decoded data path for the current instruction
    typedef struct packed {
        logic scan; // boundary chain between tdi and tdo
        logic drive; // boundary chain owns the pins
    } path_t;

endpackage

// >>> test/jtag_debug_props.sv
`timescale 1ns/1ps

// watches the top-level ports only
module jtag_debug_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic trst_n,
    input wire logic chip_reset_req,
    input wire logic cpu_debug_irq,
    input wire logic cpu_wake,
    input wire logic pin_drive,
    input wire logic tdo_oe,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    quiet_after_reset_a: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !cpu_wake)
        else $error("bus answer or pulse right after reset");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
        ##2 s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    wake_pulse_a: assert property (cpu_wake |=> !cpu_wake)
        else $error("wake longer than one cycle");
    dbg_irq_pulse_a: assert property (cpu_debug_irq |=> !cpu_debug_irq)
        else $error("debug interrupt longer than one cycle");
    port_reset_a: assert property (!trst_n [*4] |=> !chip_reset_req && !pin_drive && !tdo_oe)
        else $error("port not held in reset");
    // main scenarios reached
    cover property (cpu_wake);
    cover property (cpu_debug_irq);
    cover property (pin_drive);
    cover property (!trst_n [*4]);
endmodule

bind jtag_debug_tap_port jtag_debug_props chk (.*);

// >>> test/jtag_host_model.sv
`timescale 1ns/1ps

// probe model: tck stands low between frames
module jtag_host_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b0;
    end

    // one 400 ns period, tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #200 tck = 1'b1;
        q = tdo;
        #200 tck = 1'b0;
        tdi = ~d; // released line must not look stable
    endtask

    // five ones reach test-logic-reset from anywhere, then idle
    task automatic tlr;
        logic b;
        repeat (5) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask

    task automatic port_reset(input int ns);
        #7 trst_n = 1'b0;
        #(ns) trst_n = 1'b1;
        tlr();
    endtask

    // idle to shift, n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [15:0] d, output logic [15:0] q);
        logic b;
        q = '0;
        #7; // keeps tck edges off the clk edges
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
    typedef struct { logic [3:0] op; logic [3:0] ev; logic crr; logic drv; } row_t;
    // command, status seen, chip reset, pins driven; no reserved codes
    row_t rows [8] = '{'{4'h0, 4'h8, 1'b0, 1'b1}, '{4'h7, 4'hC, 1'b1, 1'b0}, '{4'h6, 4'hC, 1'b0, 1'b0},
        '{4'hA, 4'h9, 1'b0, 1'b0}, '{4'hB, 4'h9, 1'b0, 1'b0}, '{4'h1, 4'hA, 1'b0, 1'b0},
        '{4'h4, 4'h8, 1'b0, 1'b0}, '{4'hF, 4'h8, 1'b0, 1'b0}};
    logic clk = 1'b0, rst = 1'b1, system_reset_pin_n = 1'b0, debug_mode_select_pin = 1'b0;
    logic tck, tms, tdi, trst_n, tdo, chip_reset_req, irq, pin_drive;
    logic [7:0] pin_in = 8'hA5, pin_out, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] q, prev = 16'hFFFF;
    int miscompares = 0, samples_checked = 0;

    jtag_debug_tap_port #(.BSR_W(8)) uut (.*, .tdo_oe(), .cpu_debug_irq(), .cpu_wake());
    jtag_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

    always #25 clk = ~clk;

    // ready follows valid by a cycle, so the slave must hold
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            s_axi_bready <= s_axi_bvalid && !s_axi_bready;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            s_axi_rready <= s_axi_rvalid && !s_axi_rready;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog, well beyond the run
    initial
    begin
        #1000000;
        miscompares++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        system_reset_pin_n <= 1'b1;
        @(posedge clk);
        debug_mode_select_pin <= 1'b1;
        host.port_reset(500);
        axw(8'h08, 32'hF, rs);
        axr(8'h0C, rd, rs);
        `CHK(rd, 32'h1)
        axr(8'h00, rd, rs);
        `CHK(rd, 32'hFFFF)
        host.scan(1'b0, 8, 16'h005B, q);
        `CHK(q, 16'h00B6)
        // per command: clear, load, check
        foreach (rows[i])
        begin
            axw(8'h04, 32'hF, rs);
            host.scan(1'b1, 16, {rows[i].op, 12'hFFF}, q);
            `CHK(q, prev)
            axr(8'h04, rd, rs);
            `CHK(rd, {28'h0, rows[i].ev})
            `CHK(irq, 1'b1)
            `CHK(chip_reset_req, rows[i].crr)
            `CHK(pin_drive, rows[i].drv)
            prev = {rows[i].op, 12'hFFF};
            axr(8'h00, rd, rs);
            `CHK(rd, {16'h0, prev})
        end
        // external test: capture pins, then drive them
        host.scan(1'b1, 16, 16'h0FFF, q);
        host.scan(1'b0, 8, 16'h003C, q);
        `CHK(q[7:0], pin_in)
        `CHK(pin_out, 8'h3C)
        // port reset in mid-run drops a held chip reset
        host.scan(1'b1, 16, 16'h7FFF, q);
        `CHK(chip_reset_req, 1'b1)
        host.port_reset(300);
        `CHK(chip_reset_req, 1'b0)
        axr(8'h00, rd, rs);
        `CHK(rd, 32'hFFFF)
        host.scan(1'b1, 16, 16'h4FFF, q);
        host.tlr();
        axr(8'h00, rd, rs);
        `CHK(rd, 32'hFFFF)
        // masking, clearing and refused accesses
        axw(8'h08, 32'h0, rs);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        axw(8'h04, 32'hF, rs);
        axr(8'h04, rd, rs);
        `CHK(rd, 32'h0)
        axw(8'h00, 32'h0, rs);
        `CHK(rs, 2'h2)
        axr(8'h10, rd, rs);
        `CHK({rs, rd}, {2'h2, 32'h0})
        // strap high: normal mode, commands do nothing
        system_reset_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        system_reset_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        axr(8'h0C, rd, rs);
        `CHK(rd, 32'h0)
        host.scan(1'b1, 16, 16'h7FFF, q);
        `CHK(chip_reset_req, 1'b0)
        end_of_test();
    end
endmodule
